// File: rtl/arsc_pkg.sv
// constants, field layout and enumerations of the converter reference control block
// assumes a special-function register bus with 8-bit address and data, one clock domain
package arsc_pkg;
   localparam logic [7:0] ARSC_ADDR_REF_CTRL  = 8'hD1;
   localparam logic [7:0] ARSC_REF_CTRL_RESET = 8'h18;
   localparam logic [7:0] ARSC_REF_CTRL_WMASK = 8'h3D;
   localparam int         ARSC_BIT_GND_SEL    = 5;
   localparam int         ARSC_BIT_SEL_HI     = 4;
   localparam int         ARSC_BIT_SEL_LO     = 3;
   localparam int         ARSC_BIT_TEMP_EN    = 2;
   localparam int         ARSC_BIT_PREC_OE    = 0;

   // reference source codes
   localparam logic [1:0] ARSC_SRC_REF_PIN    = 2'h0;
   localparam logic [1:0] ARSC_SRC_MAIN_SUP   = 2'h1;
   localparam logic [1:0] ARSC_SRC_DIG_SUP    = 2'h2;
   localparam logic [1:0] ARSC_SRC_HS_REF     = 2'h3;

   // converter ground choices
   typedef enum logic [1:0] {
      ARSC_GND_PIN,
      ARSC_GND_ANALOG,
      ARSC_GND_CHIP
   } arsc_gnd_t;

   // converter phase as seen by this block
   typedef enum logic [1:0] {
      ARSC_PH_IDLE,
      ARSC_PH_SAMPLE,
      ARSC_PH_CONVERT
   } arsc_phase_t;
endpackage

// File: rtl/arsc_gnd_sel.sv
// ground reference multiplexer control for one converter phase
// assumes phase and channel information are synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module arsc_gnd_sel
   import arsc_pkg::*;
(
   input  wire logic                  gnd_sel_analog,
   input  wire logic                  hs_ref_selected,
   input  wire logic                  temp_channel,
   input  wire arsc_pkg::arsc_phase_t phase,
   output var  arsc_pkg::arsc_gnd_t   gnd_choice
);
   import arsc_pkg::*;

   // ---------------------------------------------------------------
   // ground choice
   // ---------------------------------------------------------------
   // overrides first, then the software choice
   wire       force_smp = (phase == ARSC_PH_SAMPLE) && temp_channel;
   wire       force_cnv = (phase == ARSC_PH_CONVERT) && hs_ref_selected;
   assign gnd_choice = (force_smp || force_cnv) ? ARSC_GND_CHIP
                     : (gnd_sel_analog ? ARSC_GND_ANALOG : ARSC_GND_PIN);
endmodule
`default_nettype wire

// File: rtl/arsc_ref_ctrl.sv
// voltage and ground reference selection control with its control register
// assumes a single-cycle special-function register bus on the system clock
// assumes converter phase and channel levels come from logic on the same clock
// analog switches and reference cells sit outside; only their controls are driven here
`timescale 1ns/1ps
`default_nettype none
module arsc_ref_ctrl
   import arsc_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic [7:0]           sfr_addr,
   input  wire logic [7:0]           sfr_wdata,
   input  wire logic                 sfr_wr,
   input  wire logic                 sfr_rd,
   output logic      [7:0]           sfr_rdata,
   output logic                      sfr_hit,
   input  wire logic                 conv_sample,
   input  wire logic                 conv_convert,
   input  wire logic                 conv_temp_channel,
   output logic      [1:0]           reference_source_select,
   output logic                      ref_pin_route,
   output logic                      main_supply_route,
   output logic                      dig_supply_route,
   output logic                      hs_ref_route,
   output logic                      hs_ref_power,
   output logic                      precision_ref_power,
   output logic                      reference_pin_connect,
   output logic                      temp_sensor_power,
   output var arsc_pkg::arsc_gnd_t   converter_ground
);
   import arsc_pkg::*;

   // ---------------------------------------------------------------
   // register access
   // ---------------------------------------------------------------
   logic [7:0]  ctrl_q;
   logic [7:0]  ctrl_d;
   arsc_phase_t phase;
   logic        hs_power_q;
   logic        hs_power_d;
   logic [3:0]  route_vec;

   // address decode shared by the bus logic and the write check
   function automatic logic addr_match(input logic [7:0] a);
      return (a == ARSC_ADDR_REF_CTRL);
   endfunction

   // converter activity terms shared by power control and the checks
   wire conv_busy      = conv_sample || conv_convert;
   wire temp_sample_on = conv_sample && conv_temp_channel;
   wire hs_convert_on  = !conv_sample && conv_convert && hs_ref_route;

   // decode and next value; reserved bits never take write data
   wire sel_hit = addr_match(sfr_addr);
   wire wr_hit  = sfr_wr && sel_hit;
   assign ctrl_d = wr_hit ? (sfr_wdata & ARSC_REF_CTRL_WMASK) : ctrl_q;
   assign sfr_hit = sel_hit && (sfr_wr || sfr_rd);
   assign sfr_rdata = (sfr_rd && sel_hit) ? (ctrl_q & ARSC_REF_CTRL_WMASK) : 8'h00;

   // control register
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_q <= ARSC_REF_CTRL_RESET;
      else
         ctrl_q <= ctrl_d;
   end

   // ---------------------------------------------------------------
   // reference routing
   // ---------------------------------------------------------------
   wire [1:0] src = ctrl_q[ARSC_BIT_SEL_HI:ARSC_BIT_SEL_LO];
   assign reference_source_select = src;

   // one decode term per source code; a two-bit field keeps exactly one high
   for (genvar g = 0; g < 4; g++)
   begin : g_route
      assign route_vec[g] = (src == 2'(g));
   end

   // named routing controls picked out of the decode vector
   assign ref_pin_route     = route_vec[ARSC_SRC_REF_PIN];
   assign main_supply_route = route_vec[ARSC_SRC_MAIN_SUP];
   assign dig_supply_route  = route_vec[ARSC_SRC_DIG_SUP];
   assign hs_ref_route      = route_vec[ARSC_SRC_HS_REF];
   assign precision_ref_power   = ctrl_q[ARSC_BIT_PREC_OE];
   assign reference_pin_connect = ctrl_q[ARSC_BIT_PREC_OE];
   assign temp_sensor_power     = ctrl_q[ARSC_BIT_TEMP_EN];

   // converter phase; sampling takes priority if both are raised
   assign phase = conv_sample  ? ARSC_PH_SAMPLE
                : conv_convert ? ARSC_PH_CONVERT : ARSC_PH_IDLE;

   // high-speed reference powered while it is selected and the converter is busy, and for one cycle after
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         hs_power_q <= 1'b0;
      else
         hs_power_q <= hs_power_d;
   end

   // power rises with activity at once; the held copy keeps it up one more
   // cycle so a conversion starting one idle cycle after a sample never sees a gap
   assign hs_power_d   = hs_ref_route && conv_busy;
   assign hs_ref_power = hs_power_q || hs_power_d;

   // ground selection
   arsc_gnd_sel arsc_gnd_sel_i
   (
      .gnd_sel_analog  (ctrl_q[ARSC_BIT_GND_SEL]),
      .hs_ref_selected (hs_ref_route),
      .temp_channel    (conv_temp_channel),
      .phase           (phase),
      .gnd_choice      (converter_ground)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_write_hit;
      sfr_wr && addr_match(sfr_addr);
   endsequence

   // converter busy while the high-speed reference is selected
   sequence s_hs_busy;
      hs_ref_route && conv_busy;
   endsequence

   a_write_updates: assert property (@(posedge clk) disable iff (!arst_n)
      s_write_hit |=> (ctrl_q == ($past(sfr_wdata) & ARSC_REF_CTRL_WMASK)))
      else $error("control write not stored");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
      ((ctrl_q & ~ARSC_REF_CTRL_WMASK) == 8'h00))
      else $error("reserved bits not zero");
   a_read_value: assert property (@(posedge clk) disable iff (!arst_n)
      (sfr_rd && sel_hit) |-> (sfr_rdata == ctrl_q))
      else $error("read value differs from register");
   a_route_onehot: assert property (@(posedge clk) disable iff (!arst_n)
      $onehot({ref_pin_route, main_supply_route, dig_supply_route, hs_ref_route}))
      else $error("reference routing not one-hot");
   a_hs_idle_off: assert property (@(posedge clk) disable iff (!arst_n)
      (!conv_sample && !conv_convert)[*2] |-> !hs_ref_power)
      else $error("high-speed reference powered while idle");
   a_hs_busy_on: assert property (@(posedge clk) disable iff (!arst_n)
      (hs_ref_route && conv_convert) |-> hs_ref_power)
      else $error("high-speed reference not powered in conversion");
   a_prec_follow: assert property (@(posedge clk) disable iff (!arst_n)
      s_write_hit |=> (precision_ref_power == $past(sfr_wdata[ARSC_BIT_PREC_OE])))
      else $error("precision reference enable not applied");
   a_temp_gnd: assert property (@(posedge clk) disable iff (!arst_n)
      (conv_sample && conv_temp_channel) |-> (converter_ground == ARSC_GND_CHIP))
      else $error("temperature sampling not on chip ground");
   a_hs_gnd: assert property (@(posedge clk) disable iff (!arst_n)
      (!conv_sample && conv_convert && hs_ref_route) |-> (converter_ground == ARSC_GND_CHIP))
      else $error("high-speed conversion not on chip ground");
   a_agnd_use: assert property (@(posedge clk) disable iff (!arst_n)
      (ctrl_q[ARSC_BIT_GND_SEL] && !hs_ref_route && !conv_temp_channel && conv_busy)
      |-> (converter_ground == ARSC_GND_ANALOG))
      else $error("analog ground not used");
   a_temp_power: assert property (@(posedge clk) disable iff (!arst_n)
      s_write_hit |=> (temp_sensor_power == $past(sfr_wdata[ARSC_BIT_TEMP_EN])))
      else $error("sensor enable not applied");

   // ---------------------------------------------------------------
   // checks on refused accesses and the decode flag
   // ---------------------------------------------------------------
   // a strobe to any other address leaves the register alone
   a_write_refused: assert property (@(posedge clk) disable iff (!arst_n)
      !wr_hit |=> $stable(ctrl_q))
      else $error("control register changed without a write");
   // reads of other addresses return zero
   a_read_refused: assert property (@(posedge clk) disable iff (!arst_n)
      (sfr_rd && !sel_hit) |-> (sfr_rdata == 8'h00))
      else $error("read of another address not zero");
   // decode flag raised for an access to the register
   a_hit_raised: assert property (@(posedge clk) disable iff (!arst_n)
      (sel_hit && (sfr_wr || sfr_rd)) |-> sfr_hit)
      else $error("access to the register not flagged");
   // decode flag quiet for any other address
   a_hit_quiet: assert property (@(posedge clk) disable iff (!arst_n)
      !sel_hit |-> !sfr_hit)
      else $error("decode flag raised for another address");

   // ---------------------------------------------------------------
   // checks on reference controls
   // ---------------------------------------------------------------
   // the source field takes the written code on the next edge
   a_src_field: assert property (@(posedge clk) disable iff (!arst_n)
      s_write_hit
      |=> (reference_source_select == $past(sfr_wdata[ARSC_BIT_SEL_HI:ARSC_BIT_SEL_LO])))
      else $error("source select not applied");
   // power still held in the first idle cycle after activity
   a_hs_tail: assert property (@(posedge clk) disable iff (!arst_n)
      (s_hs_busy ##1 !conv_busy) |-> hs_ref_power)
      else $error("high-speed reference dropped too early");
   // never powered once the fast reference has been deselected for a cycle
   a_hs_needs_sel: assert property (@(posedge clk) disable iff (!arst_n)
      (!hs_ref_route && !$past(hs_ref_route)) |-> !hs_ref_power)
      else $error("high-speed reference powered while not selected");
   // precision reference power and pin switch both follow the enable bit
   a_prec_pin: assert property (@(posedge clk) disable iff (!arst_n)
      (precision_ref_power == ctrl_q[ARSC_BIT_PREC_OE])
      && (reference_pin_connect == ctrl_q[ARSC_BIT_PREC_OE]))
      else $error("precision reference controls disagree with enable");
   // sensor unpowered while its enable is clear
   a_temp_off: assert property (@(posedge clk) disable iff (!arst_n)
      !ctrl_q[ARSC_BIT_TEMP_EN] |-> !temp_sensor_power)
      else $error("sensor powered while disabled");
   // sensor powered while its enable is set
   a_temp_on: assert property (@(posedge clk) disable iff (!arst_n)
      ctrl_q[ARSC_BIT_TEMP_EN] |-> temp_sensor_power)
      else $error("sensor unpowered while enabled");

   // ---------------------------------------------------------------
   // checks on ground selection
   // ---------------------------------------------------------------
   // ordinary ground pin used when software asks for it and nothing overrides
   a_gnd_pin_use: assert property (@(posedge clk) disable iff (!arst_n)
      (!ctrl_q[ARSC_BIT_GND_SEL] && !temp_sample_on && !hs_convert_on)
      |-> (converter_ground == ARSC_GND_PIN))
      else $error("ordinary ground pin not used");
   // analog ground kept while sampling an external channel, whatever the source
   a_agnd_sample: assert property (@(posedge clk) disable iff (!arst_n)
      (ctrl_q[ARSC_BIT_GND_SEL] && conv_sample && !conv_temp_channel)
      |-> (converter_ground == ARSC_GND_ANALOG))
      else $error("analog ground not used while sampling");
endmodule
`default_nettype wire

// File: verif/arsc_core_model.sv
// processor core model: drives the register bus of the reference control block
// assumes the bench calls its tasks; bus lines change only at falling edges
`timescale 1ns/1ps
`default_nettype none
module arsc_core_model
(
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   output var  logic [7:0] addr,
   output var  logic [7:0] wdata,
   output var  logic       wr,
   output var  logic       rd
);
   initial {addr, wdata, wr, rd} = 18'h0;
   // one write strobe, then released lines carry inverted values
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {addr, wdata, wr} = {a, d, 1'b1};
      @(negedge clk);
      {addr, wdata, wr} = {~a, ~d, 1'b0};
   endtask
   // read strobe held from one falling edge to the next; data taken at the rising edge between
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      {addr, rd} = {a, 1'b1};
      @(posedge clk);
      d = rdata;
      @(negedge clk);
      {addr, rd} = {~a, 1'b0};
   endtask
endmodule
`default_nettype wire

// File: verif/arsc_ref_ctrl_tb.sv
// bench for the reference control block: random register traffic and phases
// assumes the core model owns the register bus; phase levels are driven here
`timescale 1ns/1ps
`default_nettype none
module arsc_ref_ctrl_tb;
   import arsc_pkg::*;
   logic        clk, arst_n, smp, cnv, tmp, wr, rd, hit, ra, ma, da, ha, hp, pp, pc, tp, pa;
   logic [7:0]  addr, wdata, rdata, rv, ev, wv;
   logic [1:0]  sel;
   arsc_gnd_t   gnd;
   logic [15:0] lfsr = 16'hB94E;
   int          error_cnt = 0;
   int          n_tests = 0;
   int          cyc = 0;
   arsc_core_model arsc_core_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));
   arsc_ref_ctrl arsc_ref_ctrl_i (.clk(clk), .arst_n(arst_n), .sfr_addr(addr),
      .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .sfr_hit(hit),
      .conv_sample(smp), .conv_convert(cnv), .conv_temp_channel(tmp),
      .reference_source_select(sel), .ref_pin_route(ra), .main_supply_route(ma),
      .dig_supply_route(da), .hs_ref_route(ha), .hs_ref_power(hp),
      .precision_ref_power(pp), .reference_pin_connect(pc), .temp_sensor_power(tp),
      .converter_ground(gnd));
   // next random word
   function automatic logic [15:0] step(input logic [15:0] l);
      return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
   endfunction
   // expected ground: chip ground forced by sensor sampling or fast-reference conversion
   function automatic logic [1:0] exp_gnd(input logic [7:0] r, input logic s, c, t);
      if ((s && t) || (!s && c && r[4:3] == 2'h3))
         return 2'h2;
      return r[5] ? 2'h1 : 2'h0;
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // clock and hang limit
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   // decode flag against the bus lines as they stand at each rising edge
   always @(posedge clk)
   begin
      if (arst_n)
         chk({7'h0, hit}, {7'h0, (wr || rd) && (addr == 8'hD1)});
   end
   // two reset passes, each with random writes and every phase combination
   initial
   begin
      {arst_n, smp, cnv, tmp, pa} = 5'h0;
      for (int r = 0; r < 2; r++)
      begin
         @(negedge clk);
         arst_n = 1'b0;
         repeat (3) @(negedge clk);
         arst_n = 1'b1;
         arsc_core_model_i.read(8'hD1, rv);
         chk(rv, 8'h18);
         for (int i = 0; i < 16; i++)
         begin
            lfsr = step(lfsr);
            // corners: all ones enables the precision reference from off while the
            // bench clock stands in for the system clock; all zeros is the external
            // reference setup; then codes 01 and 10 with reserved bits written high
            wv = (i == 0) ? 8'hFF : (i == 1) ? 8'h00
               : (i == 2) ? 8'h0A : (i == 3) ? 8'hD4 : lfsr[7:0];
            ev = wv & 8'h3D;
            arsc_core_model_i.write(8'hD1, wv);
            arsc_core_model_i.write(8'hD2, ~wv);
            arsc_core_model_i.read(8'hD1, rv);
            chk(rv, ev);
            arsc_core_model_i.read(8'hD0, rv);
            chk(rv, 8'h00);
            chk({6'h0, sel}, {6'h0, ev[4:3]});
            chk({4'h0, ra, ma, da, ha}, 8'h08 >> ev[4:3]);
            chk({6'h0, pp, pc}, {6'h0, ev[0], ev[0]});
            chk({7'h0, tp}, {7'h0, ev[2]});
            for (int k = 0; k < 9; k++)
            begin
               @(negedge clk);
               {smp, cnv, tmp} = (k == 8) ? 3'h0 : k[2:0] ^ lfsr[10:8];
               #1;
               chk({6'h0, gnd}, {6'h0, exp_gnd(ev, smp, cnv, tmp)});
               chk({7'h0, hp}, {7'h0, ev[4:3] == 2'h3 && (smp || cnv || pa)});
               pa = smp || cnv;
            end
            @(negedge clk);
            #1;
            chk({7'h0, hp}, 8'h00);
         end
      end
      complete_run();
   end
endmodule
`default_nettype wire
